// file: design/psm_ctrl.sv
// power saving mode controller: deep and light sleep entry, wakeup, recovery
// assumes synchronous inputs and a register master that never waits
`timescale 1ns/1ps
`default_nettype none
`include "psm_cfg.svh"

module psm_ctrl #(
   parameter int RECOVERY_CYCLES = `PSM_RECOVERY_CYCLES,
   parameter int IDLE_TICKS = `PSM_IDLE_TICKS
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // wakeup and timer status
   input wire logic i_multi_input_wakeup,
   input wire logic i_pwm_timer_run,
   // clock and power controls
   output logic o_osc_enable,
   output logic o_multiplier_enable,
   output logic o_fast_instr_clock_select,
   output logic o_timer_clock_select,
   output logic o_timer0_enable,
   output logic o_analog_enable,
   output logic o_cpu_run,
   output logic o_pwm_timer_clock_enable,
   output logic o_deep_sleep,
   output logic o_light_sleep
);
   localparam int CW = 32;

   psm_pkg::psm_state_type state_reg, state_next;
   logic [CW-1:0] recov_reg, recov_next;
   logic [CW-1:0] tick_reg, tick_next;
   logic [7:0] scale_reg, scale_next;
   logic clear_seen_reg, clear_seen_next;
   logic [7:0] rdata_reg, rdata_next;
   logic wr_entry, wr_scale, wr_clear;
   logic deep_req, light_req;

   // register write decode
   always_comb begin
      wr_entry = i_wr && (i_addr == `PSM_ENTRY_ADDR);
      wr_scale = i_wr && (i_addr == `PSM_SCALE_ADDR);
      wr_clear = i_wr && (i_addr == `PSM_CLEAR_ADDR);
      deep_req = wr_entry && i_wdata[`PSM_DEEP_BIT];
      light_req = wr_entry && i_wdata[`PSM_LIGHT_BIT] && !i_wdata[`PSM_DEEP_BIT];
   end

   // mode sequencing; request bits live only as the state itself
   always_comb begin
      state_next = state_reg;
      recov_next = recov_reg;
      tick_next = tick_reg;
      clear_seen_next = clear_seen_reg;
      if (wr_clear && i_wdata == 8'h00) begin
         clear_seen_next = 1'b1;
      end
      unique case (state_reg)
         psm_pkg::PSM_RUN: begin
            if (recov_reg != '0) begin
               recov_next = recov_reg - 1'b1;
            end else if (deep_req) begin
               state_next = psm_pkg::PSM_DEEP;
               clear_seen_next = 1'b0;
            end else if (light_req) begin
               state_next = psm_pkg::PSM_LIGHT;
               tick_next = '0;
               clear_seen_next = 1'b0;
            end
         end
         psm_pkg::PSM_DEEP: begin
            // only the wakeup pins may end this state
            if (i_multi_input_wakeup) begin
               state_next = psm_pkg::PSM_RUN;
               recov_next = CW'(RECOVERY_CYCLES);
            end
         end
         psm_pkg::PSM_LIGHT: begin
            tick_next = tick_reg + 1'b1;
            if (i_multi_input_wakeup || tick_reg == CW'(IDLE_TICKS - 1)) begin
               state_next = psm_pkg::PSM_RUN;
            end
         end
         default: begin
            state_next = psm_pkg::PSM_RUN;
         end
      endcase
   end

   // clock scaling control register
   always_comb begin
      scale_next = scale_reg;
      if (wr_scale) begin
         scale_next[`PSM_MULT_EN_BIT] = i_pwm_timer_run ? scale_reg[`PSM_MULT_EN_BIT] : i_wdata[`PSM_MULT_EN_BIT];
         // selects frozen while the pwm timer runs
         if (!i_pwm_timer_run) begin
            scale_next[`PSM_TMR_SEL_BIT] = i_wdata[`PSM_TMR_SEL_BIT] && scale_next[`PSM_MULT_EN_BIT];
         end
         // writes that leave the multiplier off force the fast select low
         // uses the enable as written, so fast select never stands with the multiplier enable bit clear
         scale_next[`PSM_FAST_SEL_BIT] = i_wdata[`PSM_FAST_SEL_BIT] && scale_next[`PSM_MULT_EN_BIT];
         if (i_pwm_timer_run) begin
            scale_next[`PSM_FAST_SEL_BIT] = scale_reg[`PSM_FAST_SEL_BIT];
         end
      end
      scale_next[7:3] = 5'h00;
   end

   // read mux; entry register reads as zero since its bits are write-only
   always_comb begin
      rdata_next = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            `PSM_SCALE_ADDR: rdata_next = scale_reg;
            `PSM_STATUS_ADDR: rdata_next = {4'h0, (recov_reg != '0), clear_seen_reg,
                                            state_reg == psm_pkg::PSM_LIGHT, state_reg == psm_pkg::PSM_DEEP};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // state registers
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_reg <= psm_pkg::PSM_RUN;
         recov_reg <= '0;
         tick_reg <= '0;
         scale_reg <= `PSM_SCALE_RESET;
         clear_seen_reg <= 1'b1;
         rdata_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         recov_reg <= recov_next;
         tick_reg <= tick_next;
         scale_reg <= scale_next;
         clear_seen_reg <= clear_seen_next;
         rdata_reg <= rdata_next;
      end
   end

   // power domain outputs
   always_comb begin
      o_rdata = rdata_reg;
      o_deep_sleep = state_reg == psm_pkg::PSM_DEEP;
      o_light_sleep = state_reg == psm_pkg::PSM_LIGHT;
      o_osc_enable = !o_deep_sleep;
      o_multiplier_enable = scale_reg[`PSM_MULT_EN_BIT] && !o_deep_sleep;
      o_fast_instr_clock_select = scale_reg[`PSM_FAST_SEL_BIT];
      o_timer_clock_select = scale_reg[`PSM_TMR_SEL_BIT];
      o_timer0_enable = !o_deep_sleep;
      o_analog_enable = state_reg == psm_pkg::PSM_RUN;
      o_cpu_run = (state_reg == psm_pkg::PSM_RUN) && (recov_reg == '0);
      // pwm timer clock on in run, follows timer clock select in light sleep, off in deep sleep
      o_pwm_timer_clock_enable = (state_reg == psm_pkg::PSM_RUN) ||
                                 (o_light_sleep && scale_reg[`PSM_TMR_SEL_BIT]);
   end
endmodule
`default_nettype wire

// file: include/psm_cfg.svh
// constants for the power saving mode controller
// assumes a 200 MHz core clock and an 8-bit register port
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

// register offsets
`define PSM_ENTRY_ADDR 8'hB7
`define PSM_CLEAR_ADDR 8'hB8
`define PSM_SCALE_ADDR 8'hB9
`define PSM_STATUS_ADDR 8'hBA

// entry register fields
`define PSM_DEEP_BIT 0
`define PSM_LIGHT_BIT 1

// clock scaling fields
`define PSM_MULT_EN_BIT 0
`define PSM_FAST_SEL_BIT 1
`define PSM_TMR_SEL_BIT 2
`define PSM_SCALE_RESET 8'h00

// timing
`define PSM_CLK_PERIOD_NS 5
`define PSM_IDLE_TICKS 8192
`define PSM_RECOVERY_NS 1000
`define PSM_RECOVERY_CYCLES ((`PSM_RECOVERY_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)

`endif

// file: include/psm_pkg.sv
// types for the power saving mode controller
// used together with psm_cfg.svh
package psm_pkg;
   typedef enum logic [2:0] {
      PSM_RUN = 3'b001,
      PSM_DEEP = 3'b010,
      PSM_LIGHT = 3'b100
   } psm_state_type;
endpackage

// file: test/psm_ctrl_checker.sv
// assertions on the power saving mode controller ports
// bound to psm_ctrl from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_checker #(
   parameter int RECOVERY_CYCLES = 4,
   parameter int IDLE_TICKS = 16
) (
   // watched ports, grouped to keep the file short
   input wire logic i_clock, i_rst_n, i_wr, i_multi_input_wakeup, i_pwm_timer_run,
   input wire logic [7:0] i_addr, i_wdata,
   input wire logic o_osc_enable, o_multiplier_enable, o_fast_instr_clock_select, o_timer_clock_select,
   input wire logic o_analog_enable, o_cpu_run, o_pwm_timer_clock_enable, o_deep_sleep, o_light_sleep
);
   localparam int LIGHT_MAX = IDLE_TICKS + 2;
   wire ent = i_wr && i_addr == 8'hB7 && o_cpu_run;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   AST_DEEP_ENTRY: assert property (ent && i_wdata[0] |=> o_deep_sleep && !o_light_sleep)
      else $error("deep sleep not entered");
   AST_LIGHT_ENTRY: assert property (ent && i_wdata[1:0] == 2'h2 |=> o_light_sleep)
      else $error("light sleep not entered");
   AST_DEEP_OFF: assert property (o_deep_sleep |-> !o_osc_enable && !o_analog_enable && !o_multiplier_enable)
      else $error("circuit alive in deep sleep");
   AST_DEEP_HOLD: assert property (o_deep_sleep && !i_multi_input_wakeup |=> o_deep_sleep)
      else $error("deep sleep left without wakeup");
   AST_DEEP_WAKE: assert property (o_deep_sleep && i_multi_input_wakeup |=> !o_cpu_run ##RECOVERY_CYCLES o_cpu_run)
      else $error("recovery delay wrong");
   AST_LIGHT_WAKE: assert property (o_light_sleep && i_multi_input_wakeup |=> !o_light_sleep && o_cpu_run)
      else $error("light wake not next cycle");
   AST_LIGHT_TIMEOUT: assert property ($rose(o_light_sleep) |-> ##[1:LIGHT_MAX] !o_light_sleep)
      else $error("light sleep overflow missing");
   AST_LIGHT_STATE: assert property (o_light_sleep |-> o_osc_enable && !o_cpu_run && !o_analog_enable &&
      o_pwm_timer_clock_enable == o_timer_clock_select)
      else $error("light sleep outputs wrong");
   AST_FAST_NEEDS_MULT: assert property ($rose(o_fast_instr_clock_select) |-> o_multiplier_enable)
      else $error("fast select set with multiplier off");
   AST_SEL_LOCK: assert property (i_pwm_timer_run |=> $stable(o_fast_instr_clock_select) && $stable(o_timer_clock_select))
      else $error("select changed while timer runs");
   COV_DEEP: cover property (o_deep_sleep && i_multi_input_wakeup);
   COV_LIGHT_PIN: cover property (o_light_sleep && i_multi_input_wakeup);
   COV_LIGHT_TIMEOUT: cover property ($fell(o_light_sleep) && !$past(i_multi_input_wakeup));
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking testbench for the power saving mode controller
// drives the register port, wakeup pin and timer status directly
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_multi_input_wakeup = 0, i_pwm_timer_run = 0;
   logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
   logic o_osc_enable, o_multiplier_enable, o_fast_instr_clock_select, o_timer_clock_select, o_timer0_enable;
   logic o_analog_enable, o_cpu_run, o_pwm_timer_clock_enable, o_deep_sleep, o_light_sleep;
   int error_cnt = 0, checked = 0, n;
   // short counts keep the run brief
   psm_ctrl #(.RECOVERY_CYCLES(4), .IDLE_TICKS(16)) psm_ctrl_i (.*);
   initial begin
      forever #2.5 i_clock = ~i_clock;
   end
   task automatic chk(input string name, input logic [7:0] exp, got);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_clock);
      {i_addr, i_wdata, i_wr} <= {a, d, 1'h1};
      @(posedge i_clock);
      i_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(posedge i_clock);
      {i_addr, i_rd} <= {a, 1'h1};
      @(posedge i_clock);
      i_rd <= 1'h0;
      #1 chk("rdata", exp, o_rdata);
   endtask
   // bounded wait, a hang ends the run
   task automatic wait_run();
      for (n = 0; n < 64 && o_cpu_run !== 1'h1; n++) @(posedge i_clock) #1;
      if (n == 64) begin
         error_cnt++;
         test_done();
      end
   endtask
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clock);
      i_rst_n <= 1'h1;
      rd(8'hB9, 8'h00);
      rd(8'h10, 8'h00);
      wr(8'hB9, 8'h02);
      rd(8'hB9, 8'h00);
      wr(8'hB9, 8'h01);
      wr(8'hB9, 8'h07);
      i_pwm_timer_run <= 1'h1;
      wr(8'hB9, 8'h01);
      rd(8'hB9, 8'h07);
      i_pwm_timer_run <= 1'h0;
      $display("clock scaling test done");
      wr(8'hB7, 8'h02);
      chk("light", 8'h03, {6'h0, o_light_sleep, o_timer0_enable});
      chk("pwm clock", 8'h01, {7'h0, o_pwm_timer_clock_enable});
      wait_run();
      rd(8'hB7, 8'h00);
      rd(8'hBA, 8'h00);
      wr(8'hB8, 8'h00);
      rd(8'hBA, 8'h04);
      wr(8'hB9, 8'h01);
      wr(8'hB9, 8'h00);
      wr(8'hB7, 8'h02);
      chk("pwm clock", 8'h00, {7'h0, o_pwm_timer_clock_enable});
      i_multi_input_wakeup <= 1'h1;
      @(posedge i_clock);
      i_multi_input_wakeup <= 1'h0;
      #1 chk("run", 8'h01, {7'h0, o_cpu_run});
      $display("light sleep test done");
      wr(8'hB7, 8'h03);
      chk("deep", 8'h04, {5'h0, o_deep_sleep, o_osc_enable, o_timer0_enable});
      repeat (8) @(posedge i_clock);
      #1 chk("deep", 8'h01, {7'h0, o_deep_sleep});
      i_multi_input_wakeup <= 1'h1;
      @(posedge i_clock);
      i_multi_input_wakeup <= 1'h0;
      #1 chk("run", 8'h00, {7'h0, o_cpu_run});
      wait_run();
      rd(8'hB7, 8'h00);
      wr(8'hB8, 8'h00);
      wr(8'hB9, 8'h01);
      repeat (8) @(posedge i_clock);
      wr(8'hB9, 8'h07);
      rd(8'hB9, 8'h07);
      $display("deep sleep test done");
      test_done();
   end
endmodule
bind psm_ctrl psm_ctrl_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES), .IDLE_TICKS(IDLE_TICKS)) psm_ctrl_checker_i (.*);
`default_nettype wire
